// ===== include/intc_regs.svh
// Register offsets, field positions, reset values and constants
// Assumes APB byte addressing with one 32-bit word per register
`ifndef INTC_REGS_SVH
`define INTC_REGS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define FLAGS_BASE      8'h00
`define ENABLES_BASE    8'h0C
`define PRIO_BASE       8'h18
`define PRIO_LAST       8'h44
`define STATUS_OFFS     8'h48
`define EXC_CTL_OFFS    8'h4C
`define EXT_CTL_OFFS    8'h50
`define LEVEL_OFFS      8'h54
// ****************************************
// Field positions
// ****************************************
`define NEST_DIS_BIT    15
`define ADDR_ERR_BIT    3
`define ALT_TABLE_BIT   15
`define TIMED_LOW_PRIORITY_MASK_BIT        14
`define EXT_POL_W       5
`define ILR_LSB         8
// ****************************************
// Reset values and constants
// ****************************************
`define FLAGS_RST       16'h0000
`define ENABLES_RST     16'h0000
`define PRIO_RST        3'h4
`define LEVEL_RST       4'h0
`define VEC_OFFSET      6'h08
`define IVT_BASE        24'h000004
`define ALTERNATE_VECTOR_TABLE_BASE       24'h000084
`define VEC_LO          24'h000004
`define VEC_HI          24'h0000FE
`define TIMED_LOW_PRIORITY_MASK_TOP_LVL    3'h6
`endif

// ===== include/intc_pkg.sv
// Types shared by the interrupt controller files
// Assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package intc_pkg;
   // Arbitration winner
   typedef struct packed {
      logic       valid;
      logic [5:0] idx;
      logic [2:0] prio;
   } arb_win_t;
   // APB slave phase, one-hot
   typedef enum logic [1:0] {
      APB_IDLE   = 2'b01,
      APB_ACCESS = 2'b10
   } apb_state_t;
endpackage
`default_nettype wire

// ===== logic/intc_arbiter.sv
// Priority arbiter: highest user level, ties to lowest number
// Assumes pending bits already gated by flags and enables
`timescale 1ns/1ps
`default_nettype none
module intc_arbiter import intc_pkg::*; #(
   parameter int N = 48
) (
   input  wire logic [N-1:0]   pend_i,  // Eligible requests
   input  wire logic [3*N-1:0] prio_i,  // Packed 3-bit levels
   output arb_win_t            win_o    // Winner
);
   // ****************************************
   // Elaboration check
   // ****************************************
   if (N < 1 || N > 64) begin : g_bad_n
      $error("intc_arbiter: N out of range");
   end
   // ****************************************
   // Search
   // ****************************************
   // Scan downward so lower numbers win ties
   always_comb begin
      win_o = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (pend_i[i] && prio_i[3*i +: 3] != 3'h0 &&
             (!win_o.valid || prio_i[3*i +: 3] >= win_o.prio)) begin
            win_o.valid = 1'b1;
            win_o.idx   = 6'(i);
            win_o.prio  = prio_i[3*i +: 3];
         end
      end
   end
endmodule // intc_arbiter
`default_nettype wire

// ===== logic/vectored_priority_interrupt_controller.sv
// Vectored priority interrupt controller with APB registers
// Assumes core gives ack/return pulses and fetch addresses
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "intc_regs.svh"
module vectored_priority_interrupt_controller import intc_pkg::*; #(
   parameter int NSRC = 48
) (
   input  wire logic        sys_clk_i,      // Core clock
   input  wire logic        reset_i,        // Sync reset
   input  wire logic        psel_i,         // APB select
   input  wire logic        penable_i,      // APB enable
   input  wire logic        pwrite_i,       // APB direction
   input  wire logic [7:0]  paddr_i,        // APB address
   input  wire logic [31:0] pwdata_i,       // APB write data
   output logic      [31:0] prdata_o,       // APB read data
   output logic             pready_o,       // APB ready
   output logic             pslverr_o,      // APB error
   input  wire logic [NSRC-1:0] src_event_i, // Source pulses
   input  wire logic        irq_ack_i,      // Core takes request
   input  wire logic        irq_return_i,   // Return from handler
   input  wire logic [3:0]  restore_level_i, // Level popped on return
   output logic             irq_req_o,      // Request to core
   output logic      [5:0]  irq_vector_o,   // Vector number
   output logic      [3:0]  irq_level_o,    // New CPU level
   output logic      [23:0] vec_addr_o,     // Vector word address
   input  wire logic        vec_valid_i,    // Vector word on bus
   input  wire logic [23:0] vec_data_i,     // Program data bus
   input  wire logic [23:0] pc_seq_i,       // Sequential PC
   output logic      [23:0] pc_next_o,      // Next PC
   input  wire logic        fetch_valid_i,  // Instruction fetch
   input  wire logic [23:0] fetch_addr_i,   // Fetch address
   input  wire logic        vector_fetch_i, // Fetch is a vector read
   input  wire logic        jump_valid_i,   // Jump executed
   input  wire logic [23:0] jump_target_i,  // Jump target
   output logic             addr_err_o,     // Address error trap
   input  wire logic        timed_low_priority_mask_start_i,   // Timed mask instruction
   input  wire logic [13:0] timed_low_priority_mask_count_i,   // Instruction count
   input  wire logic        instr_done_i,   // Instruction retired
   output logic      [3:0]  cpu_level_o,    // Current CPU level
   output logic [`EXT_POL_W-1:0] ext_pol_o  // External edge select
);
   // ****************************************
   // Elaboration check
   // ****************************************
   if (NSRC < 1 || NSRC > 48) begin : g_bad_nsrc
      $error("controller: NSRC out of range");
   end
   // ****************************************
   // State
   // ****************************************
   logic [47:0] flags_q;                  // Request flags
   logic [47:0] enables_q;                // Source enables
   logic [2:0]  prio_q [0:47];            // User levels
   logic [3:0]  cpu_level_q;              // Current level
   logic [5:0]  stat_vec_q;               // Latched vector
   logic [3:0]  stat_lvl_q;               // Latched level
   logic        nest_dis_q;               // Nesting disable
   logic        addr_flag_q;              // Sticky address error
   logic        alt_tbl_q;                // Alternate table select
   logic [13:0] timed_low_priority_mask_cnt_q;               // Mask countdown
   logic [3:0]  depth_q;                  // Nesting depth
   apb_state_t  state_q;                  // APB phase
   logic        pready_q;                 // Ready flop
   logic        pslverr_q;                // Error flop
   logic [31:0] prdata_q;                 // Read data flop
   logic        irq_req_q;                // Request flop
   logic [5:0]  irq_vec_q;                // Vector flop
   logic [3:0]  irq_lvl_q;                // Level flop
   logic [23:0] vec_addr_q;               // Vector address flop
   logic [23:0] pc_next_q;                // PC mux flop
   logic        addr_err_q;               // Trap pulse flop
   logic [`EXT_POL_W-1:0] ext_pol_q;      // Edge selects
   logic [47:0] events;                   // Padded source pulses
   logic [47:0] pend;                     // Flag and enable
   logic [143:0] prio_flat;               // Packed levels
   arb_win_t    win;                      // Arbiter result
   logic        wr_acc;                   // Write access edge
   logic        take;                     // Core accepts
   logic        ret;                      // Core returns
   logic        timed_low_priority_mask_on;                  // Mask active
   logic        bad_fetch;                // Non-vector fetch or jump into table
   // ****************************************
   // Helpers
   // ****************************************
   // True if address lies in the vector table
   function automatic logic in_vec(input logic [23:0] a);
      return (a >= `VEC_LO) && (a <= `VEC_HI);
   endfunction
   // Priority word: bit three of nibbles zero, last reg 8 bits
   function automatic logic [15:0] prio_word(input logic [3:0] r);
      logic [15:0] w;
      w = '0;
      for (int n = 0; n < 4; n++) begin
         if (r != 4'hB || n < 2) begin
            w[4*n +: 4] = {1'b0, prio_q[4*r + n]};
         end
      end
      return w;
   endfunction
   // ****************************************
   // Combinational glue
   // ****************************************
   assign events  = 48'(src_event_i);
   assign pend    = flags_q & enables_q;
   assign wr_acc  = psel_i & penable_i & pready_q & pwrite_i;
   assign take    = irq_ack_i & irq_req_q;
   assign ret     = irq_return_i & (depth_q != 4'h0);
   assign timed_low_priority_mask_on = (timed_low_priority_mask_cnt_q != 14'h0000);
   assign bad_fetch = (fetch_valid_i & ~vector_fetch_i & in_vec(fetch_addr_i)) |
                      (jump_valid_i & in_vec(jump_target_i));
   // Flatten levels for the arbiter
   always_comb begin
      prio_flat = '0;
      for (int i = 0; i < 46; i++) begin
         prio_flat[3*i +: 3] = prio_q[i];
      end
   end
   intc_arbiter #(
      .N (48)
   ) u_arb (
      .pend_i (pend),
      .prio_i (prio_flat),
      .win_o  (win)
   );
   // ****************************************
   // APB slave
   // ****************************************
   // Setup cycle answers in the next cycle
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         state_q   <= APB_IDLE;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
      end else begin
         case (state_q)
            APB_IDLE: begin
               if (psel_i && !penable_i) begin
                  state_q  <= APB_ACCESS;
                  pready_q <= 1'b1;
                  pslverr_q <= (paddr_i[1:0] != 2'h0) || (paddr_i > `LEVEL_OFFS);
                  prdata_q <= 32'h00000000;
                  // Read decode
                  if (paddr_i < `ENABLES_BASE) begin
                     prdata_q[15:0] <= flags_q[16*paddr_i[3:2] +: 16];
                  end else if (paddr_i < `PRIO_BASE) begin
                     prdata_q[15:0] <= enables_q[16*(paddr_i[5:2] - 4'h3) +: 16];
                  end else if (paddr_i <= `PRIO_LAST) begin
                     prdata_q[15:0] <= prio_word(4'(paddr_i[7:2] - 6'h06));
                  end else if (paddr_i == `STATUS_OFFS) begin
                     prdata_q[15:0] <= {4'h0, stat_lvl_q, 2'h0, stat_vec_q};
                  end else if (paddr_i == `EXC_CTL_OFFS) begin
                     prdata_q[`NEST_DIS_BIT] <= nest_dis_q;
                     prdata_q[`ADDR_ERR_BIT] <= addr_flag_q;
                  end else if (paddr_i == `EXT_CTL_OFFS) begin
                     prdata_q[`ALT_TABLE_BIT] <= alt_tbl_q;
                     prdata_q[`TIMED_LOW_PRIORITY_MASK_BIT]      <= timed_low_priority_mask_on;
                     prdata_q[`EXT_POL_W-1:0] <= ext_pol_q;
                  end else if (paddr_i == `LEVEL_OFFS) begin
                     prdata_q[3:0] <= cpu_level_q;
                  end
               end
            end
            APB_ACCESS: begin
               state_q   <= APB_IDLE;
               pready_q  <= 1'b0;
               pslverr_q <= 1'b0;
            end
            default: begin
               state_q  <= APB_IDLE;
               pready_q <= 1'b0;
            end
         endcase
      end
   end
   // ****************************************
   // Flags and enables
   // ****************************************
   // events set flags unconditionally
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         flags_q <= {3{`FLAGS_RST}};
      end else begin
         for (int r = 0; r < 3; r++) begin
            if (wr_acc && paddr_i == `FLAGS_BASE + 8'(4 * r)) begin
               flags_q[16*r +: 16] <= pwdata_i[15:0] | events[16*r +: 16];
            end else begin
               flags_q[16*r +: 16] <= flags_q[16*r +: 16] | events[16*r +: 16];
            end
         end
      end
   end
   // Enable registers
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         enables_q <= {3{`ENABLES_RST}};
      end else begin
         for (int r = 0; r < 3; r++) begin
            if (wr_acc && paddr_i == `ENABLES_BASE + 8'(4 * r)) begin
               enables_q[16*r +: 16] <= pwdata_i[15:0];
            end
         end
      end
   end
   // twelve priority registers, last half width
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         for (int i = 0; i < 48; i++) begin
            prio_q[i] <= `PRIO_RST;
         end
      end else begin
         for (int r = 0; r < 12; r++) begin
            if (wr_acc && paddr_i == `PRIO_BASE + 8'(4 * r)) begin
               for (int n = 0; n < 4; n++) begin
                  prio_q[4*r + n] <= (r == 11 && n > 1) ? 3'h0 : pwdata_i[4*n +: 3];
               end
            end
         end
      end
   end
   // ****************************************
   // Global control
   // ****************************************
   // exception and external control
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         nest_dis_q  <= 1'b0;
         addr_flag_q <= 1'b0;
         alt_tbl_q   <= 1'b0;
         ext_pol_q   <= '0;
      end else begin
         if (wr_acc && paddr_i == `EXC_CTL_OFFS) begin
            nest_dis_q  <= pwdata_i[`NEST_DIS_BIT];
            addr_flag_q <= pwdata_i[`ADDR_ERR_BIT] | bad_fetch;
         end else begin
            addr_flag_q <= addr_flag_q | bad_fetch;
         end
         if (wr_acc && paddr_i == `EXT_CTL_OFFS) begin
            alt_tbl_q <= pwdata_i[`ALT_TABLE_BIT];
            ext_pol_q <= pwdata_i[`EXT_POL_W-1:0];
         end
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         timed_low_priority_mask_cnt_q <= 14'h0000;
      end else if (timed_low_priority_mask_start_i) begin
         timed_low_priority_mask_cnt_q <= timed_low_priority_mask_count_i;
      end else if (instr_done_i && timed_low_priority_mask_on) begin
         timed_low_priority_mask_cnt_q <= timed_low_priority_mask_cnt_q - 14'h0001;
      end
   end
   // ****************************************
   // CPU level and service tracking
   // ****************************************
   // four-bit CPU level
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         cpu_level_q <= `LEVEL_RST;
      end else if (take) begin
         cpu_level_q <= irq_lvl_q;
      end else if (ret) begin
         cpu_level_q <= restore_level_i;
      end else if (wr_acc && paddr_i == `LEVEL_OFFS && !nest_dis_q) begin
         cpu_level_q <= pwdata_i[3:0];
      end
   end
   // Nesting depth
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         depth_q <= 4'h0;
      end else if (take && !ret) begin
         depth_q <= depth_q + 4'h1;
      end else if (ret && !take) begin
         depth_q <= depth_q - 4'h1;
      end
   end
   // latch vector and level on accept
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         stat_vec_q <= 6'h00;
         stat_lvl_q <= 4'h0;
         vec_addr_q <= `IVT_BASE;
      end else if (take) begin
         stat_vec_q <= irq_vec_q;
         stat_lvl_q <= irq_lvl_q;
         vec_addr_q <= (alt_tbl_q ? `ALTERNATE_VECTOR_TABLE_BASE : `IVT_BASE) + {17'h0, irq_vec_q, 1'b0};
      end
   end
   // ****************************************
   // Request to core
   // ****************************************
   // strictly above CPU level; zero never
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         irq_req_q <= 1'b0;
         irq_vec_q <= 6'h00;
         irq_lvl_q <= 4'h0;
      end else begin
         irq_vec_q <= win.idx + `VEC_OFFSET;
         irq_lvl_q <= {1'b0, win.prio};
         irq_req_q <= win.valid && ({1'b0, win.prio} > cpu_level_q) && !take &&
                      !(nest_dis_q && depth_q != 4'h0) &&
                      !(timed_low_priority_mask_on && win.prio <= `TIMED_LOW_PRIORITY_MASK_TOP_LVL);
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         pc_next_q <= 24'h000000;
      end else begin
         pc_next_q <= vec_valid_i ? vec_data_i : pc_seq_i;
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         addr_err_q <= 1'b0;
      end else begin
         addr_err_q <= bad_fetch;
      end
   end
   // ****************************************
   // Outputs
   // ****************************************
   assign prdata_o     = prdata_q;
   assign pready_o     = pready_q;
   assign pslverr_o    = pslverr_q;
   assign irq_req_o    = irq_req_q;
   assign irq_vector_o = irq_vec_q;
   assign irq_level_o  = irq_lvl_q;
   assign vec_addr_o   = vec_addr_q;
   assign pc_next_o    = pc_next_q;
   assign addr_err_o   = addr_err_q;
   assign cpu_level_o  = cpu_level_q;
   assign ext_pol_o    = ext_pol_q;
   // ****************************************
   // Assertions
   // ****************************************
   AST_FLAG_SET: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      events[0] |=> flags_q[0]) else $error("flag not set by event");
   AST_LEVEL_NONZERO: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      irq_req_o |-> irq_level_o != 4'h0) else $error("level zero presented");
   AST_ABOVE_CPU: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      irq_req_o |-> irq_level_o > $past(cpu_level_q)) else $error("request not above level");
   AST_NEST_BLOCK: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (nest_dis_q && depth_q != 4'h0) |=> !irq_req_o) else $error("nested while disabled");
   AST_LEVEL_RO: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (nest_dis_q && wr_acc && paddr_i == `LEVEL_OFFS && !take && !ret) |=> $stable(cpu_level_q))
      else $error("level written under nesting disable");
   AST_TIMED_MASK: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      timed_low_priority_mask_on |=> (!irq_req_o || irq_level_o == 4'h7)) else $error("masked level presented");
   AST_ACCEPT_LATCH: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      take |=> (stat_vec_q == $past(irq_vector_o)) && (cpu_level_q == $past(irq_level_o)))
      else $error("accept not latched");
   AST_ADDR_TRAP: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (jump_valid_i && jump_target_i == `VEC_HI) |=> addr_err_o ##1 addr_flag_q)
      else $error("vector-space jump not trapped");
endmodule // vectored_priority_interrupt_controller
`default_nettype wire

// ===== verification/intc_core_model.sv
// Core-side partner: takes requests, fetches the vector word
// Assumes the controller's request, ack and vector address ports
`timescale 1ns/1ps
`default_nettype none
module intc_core_model (
   input  wire logic        clk_i,       // Core clock
   input  wire logic        irq_req_i,   // Request from controller
   input  wire logic [23:0] vec_addr_i,  // Vector word address
   input  wire logic [1:0]  delay_i,     // Cycles of ack latency
   output logic             ack_o,       // Take pulse
   output logic             vec_valid_o, // Vector word on bus
   output logic      [23:0] vec_data_o   // Program data bus
);
   logic [1:0]  wait_q  = 2'h0;       // Latency count
   logic        fetch_q = 1'b0;       // Fetch one cycle after take
   logic        ack_q   = 1'b0;       // Take pulse flop
   logic        valid_q = 1'b0;       // Vector word flag
   logic [23:0] data_q  = 24'h000000; // Program bus value
   // One driver per output
   assign ack_o       = ack_q;
   assign vec_valid_o = valid_q;
   assign vec_data_o  = data_q;
   // Take after delay_i cycles; bus toggles when idle
   always @(posedge clk_i) begin
      ack_q <= 1'b0;
      wait_q <= 2'h0;
      if (irq_req_i && !ack_q) begin
         if (wait_q == delay_i) ack_q <= 1'b1;
         else wait_q <= wait_q + 2'h1;
      end
      fetch_q <= ack_q;
      valid_q <= fetch_q;
      data_q <= fetch_q ? (24'h100000 | vec_addr_i) : ~data_q;
   end
endmodule // intc_core_model
`default_nettype wire

// ===== verification/vectored_priority_interrupt_controller_tb.sv
// Self-checking bench for the interrupt controller
// Assumes the core model beside it and APB at 125 MHz
`timescale 1ns/1ps
`default_nettype none
module vectored_priority_interrupt_controller_tb;
   logic sys_clk_i = 1'b0, reset_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic pready, pslverr, irq_req, ack, vvalid, addr_err, err, ret = 1'b0, vfetch = 1'b0;
   logic fvalid = 1'b0, jvalid = 1'b0, dstart = 1'b0, idone = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [47:0] src = 48'h0;
   logic [5:0]  ivec;
   logic [3:0]  ilvl, lvl, rlvl = 4'h0;
   logic [4:0]  pol;
   logic [23:0] vaddr, vdata, pcn, faddr = 24'h0, jaddr = 24'h0, pcs = 24'h000200;
   logic [13:0] dcnt = 14'h0;
   logic [1:0]  slow = 2'h0;
   int n_mismatch = 0, tests_run = 0, cyc = 0, i;
   always #4 sys_clk_i = ~sys_clk_i;
   vectored_priority_interrupt_controller #(.NSRC(48)) u_vectored_priority_interrupt_controller (
      .sys_clk_i(sys_clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .src_event_i(src), .irq_ack_i(ack), .irq_return_i(ret), .restore_level_i(rlvl),
      .irq_req_o(irq_req), .irq_vector_o(ivec), .irq_level_o(ilvl), .vec_addr_o(vaddr),
      .vec_valid_i(vvalid), .vec_data_i(vdata), .pc_seq_i(pcs), .pc_next_o(pcn),
      .fetch_valid_i(fvalid), .fetch_addr_i(faddr), .vector_fetch_i(vfetch), .jump_valid_i(jvalid),
      .jump_target_i(jaddr), .addr_err_o(addr_err), .timed_low_priority_mask_start_i(dstart), .timed_low_priority_mask_count_i(dcnt),
      .instr_done_i(idone), .cpu_level_o(lvl), .ext_pol_o(pol));
   intc_core_model u_intc_core_model (.clk_i(sys_clk_i), .irq_req_i(irq_req), .vec_addr_i(vaddr),
      .delay_i(slow), .ack_o(ack), .vec_valid_o(vvalid), .vec_data_o(vdata));
   // Compare and count
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer, held until pready
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk_i);
      penable <= 1'b1;
      @(posedge sys_clk_i);
      while (pready !== 1'b1) @(posedge sys_clk_i);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk_i);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task do_reset;
      reset_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      reset_i <= 1'b0;
   endtask
   task pulse_src(input logic [47:0] m);
      src <= m;
      @(posedge sys_clk_i);
      src <= 48'h0;
   endtask
   // Wait for the vector word, then one edge for the PC
   task wait_vec;
      for (i = 0; i < 40 && vvalid !== 1'b1; i++) @(posedge sys_clk_i);
      @(posedge sys_clk_i);
   endtask
   task t_reset;
      do_reset;
      chk({8'h00, vaddr}, 32'h4);
      rdchk(8'h18, 32'h4444);
      rdchk(8'h44, 32'h0044);
      rdchk(8'h00, 32'h0);
      rdchk(8'h58, 32'h0);
      chk({31'h0, err}, 32'h1);
      $display("test reset done");
   endtask
   task t_service;
      slow <= 2'h2;
      pulse_src(48'h8);
      repeat (3) @(posedge sys_clk_i);
      rdchk(8'h00, 32'h8);
      chk({31'h0, irq_req}, 32'h0);
      wr(8'h0C, 32'h8);
      @(posedge sys_clk_i);
      chk({31'h0, irq_req}, 32'h1);
      chk({26'h0, ivec}, 32'hB);
      chk({28'h0, ilvl}, 32'h4);
      wait_vec;
      chk({8'h00, pcn}, 32'h10001A);
      rdchk(8'h48, 32'h040B);
      chk({28'h0, lvl}, 32'h4);
      chk({31'h0, irq_req}, 32'h0);
      $display("test service done");
   endtask
   task t_tie;
      do_reset;
      slow <= 2'h0;
      wr(8'h18, 32'h0550);
      wr(8'h00, 32'h0);
      wr(8'h0C, 32'h7);
      pulse_src(48'h7);
      wait_vec;
      rdchk(8'h48, 32'h0509);
      rlvl <= 4'h2;
      ret <= 1'b1;
      @(posedge sys_clk_i);
      ret <= 1'b0;
      @(posedge sys_clk_i);
      chk({28'h0, lvl}, 32'h2);
      wr(8'h4C, 32'h8000);
      wr(8'h54, 32'h0);
      rdchk(8'h54, 32'h5);
      $display("test tie done");
   endtask
   task t_mask;
      do_reset;
      wr(8'h0C, 32'h8);
      wr(8'h50, 32'h8015);
      dstart <= 1'b1;
      dcnt <= 14'h0002;
      @(posedge sys_clk_i);
      dstart <= 1'b0;
      pulse_src(48'h8);
      repeat (4) @(posedge sys_clk_i);
      chk({31'h0, irq_req}, 32'h0);
      rdchk(8'h50, 32'hC015);
      chk({27'h0, pol}, 32'h15);
      idone <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      idone <= 1'b0;
      wait_vec;
      chk({8'h00, pcn}, 32'h10009A);
      chk({8'h00, vaddr}, 32'h9A);
      rdchk(8'h48, 32'h040B);
      $display("test mask done");
   endtask
   // Fetch or jump, then look for the error pulse
   task trap(input logic j, input logic [23:0] a, input logic e);
      fvalid <= !j;
      jvalid <= j;
      faddr <= a;
      jaddr <= a;
      @(posedge sys_clk_i);
      fvalid <= 1'b0;
      jvalid <= 1'b0;
      @(posedge sys_clk_i);
      chk({31'h0, addr_err}, {31'h0, e});
      @(posedge sys_clk_i);
   endtask
   task t_trap;
      do_reset;
      trap(1'b0, 24'h000004, 1'b1);
      trap(1'b0, 24'h0000FE, 1'b1);
      trap(1'b0, 24'h000100, 1'b0);
      trap(1'b1, 24'h0000FE, 1'b1);
      trap(1'b1, 24'h000002, 1'b0);
      vfetch <= 1'b1;
      trap(1'b0, 24'h000010, 1'b0);
      vfetch <= 1'b0;
      rdchk(8'h4C, 32'h0008);
      wr(8'h4C, 32'h0);
      rdchk(8'h4C, 32'h0);
      $display("test trap done");
   endtask
   task end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Hang guard
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         end_sim;
      end
   end
   initial begin
      t_reset;
      t_service;
      t_tie;
      t_mask;
      t_trap;
      end_sim;
   end
endmodule // vectored_priority_interrupt_controller_tb
`default_nettype wire
